/* hw/fsp_regs.vh */
// register indices, field positions, reset values and codes of the flash program controller
`ifndef FSP_REGS_VH
`define FSP_REGS_VH

// register indices; byte address is four times the index
`define FSP_IDX_KEY        8'hF1
`define FSP_IDX_ADDR_LOW   8'hF2
`define FSP_IDX_ADDR_HIGH  8'hF3
`define FSP_IDX_REGION     8'hF4
`define FSP_IDX_DATA       8'hF5
`define FSP_IDX_CONTROL    8'hF6
`define FSP_IDX_STATUS     8'hF7

// reset values
`define FSP_RST_BYTE       8'h00
`define FSP_RST_STATUS     8'h00

// program_control fields
`define FSP_CTL_BOOT_BIT   7
`define FSP_CTL_ERASE_BIT  5
`define FSP_CTL_WRITE_BIT  4
`define FSP_CTL_CMD_HI     1
`define FSP_CTL_CMD_LO     0
`define FSP_CTL_RW_MASK    8'hB3
`define FSP_CMD_LAUNCH     2'h2
`define FSP_CMD_IDLE       2'h0

// status fields
`define FSP_STA_ENABLED    0
`define FSP_STA_BUSY       1
`define FSP_STA_REFUSED    2
`define FSP_STA_DONE       3

// unlock key
`define FSP_KEY_MIN        8'h40

// region selector codes
`define FSP_REG_MAIN       8'h00
`define FSP_REG_UID        8'h01
`define FSP_REG_EEPROM     8'h02
`define FSP_REG_BOOT       8'h03

// region codes driven to the array
`define FSP_AREA_MAIN      2'h0
`define FSP_AREA_UID       2'h1
`define FSP_AREA_EEPROM    2'h2
`define FSP_AREA_BOOT      2'h3

`endif

/* hw/fsp_key_timer.v */
// unlock key window: counts n clocks after a valid key write
`include "fsp_regs.vh"

module fsp_key_timer (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // control
  input  wire       key_wr_i,
  input  wire [7:0] key_val_i,
  input  wire       consume_i,
  // state
  output reg        enabled_o,
  output reg  [7:0] remaining_o
);

  reg [7:0] next_remaining;
  reg       next_enabled;

  always @* begin
    next_remaining = remaining_o;
    next_enabled   = enabled_o;
    if (key_wr_i) begin
      if (key_val_i >= `FSP_KEY_MIN) begin // [R1]
        next_remaining = key_val_i;
        next_enabled   = 1'b1;
      end else begin
        next_remaining = `FSP_RST_BYTE;
        next_enabled   = 1'b0;
      end
    end else if (consume_i) begin
      next_remaining = `FSP_RST_BYTE;
      next_enabled   = 1'b0;
    end else if (enabled_o) begin
      // window closes after n clocks with no command
      if (remaining_o == 8'h01) begin // [R2]
        next_enabled = 1'b0;
      end
      next_remaining = remaining_o - 8'h01;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      enabled_o   <= 1'b0;
      remaining_o <= `FSP_RST_BYTE;
    end else begin
      enabled_o   <= next_enabled;
      remaining_o <= next_remaining;
    end
  end

endmodule

/* hw/fsp_ctrl.v */
// self-programming controller: wishbone registers, key window, launch and stall
// Operation
// [R1] key value at least 0x40 enables programming
// [R2] window of n clocks then auto disable
// [R3] low register gives address bits 7..0
// [R4] high register gives address bits 15..8
// [R5] selector 0x00 targets main code area
// [R6] selector 0x01 reads unique id, no writes
// [R7] selector 0x02 targets independent eeprom region
// [R8] selector 0x03 boot reads only from boot
// [R9] boot select bit picks reset start area
// [R10] erase bit then code 10 erases sector
// [R11] program bit then code 10 writes byte
// [R12] only trigger code 10 launches anything
// [R13] software sets operation bit before trigger
// [R14] software never sets both operation bits
// [R15] software waits twelve nops after trigger
// [R16] boot area program or erase always refused
// [R17] watchdog holds count during flash operation
// [R18] trigger without live key does nothing; the code sets the refused status bit instead
// [R19] cpu stalled until flash operation finishes
`include "fsp_regs.vh"

module fsp_ctrl (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // flash array
  output reg         flash_write_o,
  output reg         flash_erase_o,
  output reg  [15:0] flash_addr_o,
  output reg  [1:0]  flash_area_o,
  output reg  [7:0]  flash_data_o,
  input  wire        flash_done_i,
  // table read path
  input  wire        exec_in_boot_i,
  output reg  [1:0]  read_area_o,
  output reg         read_allow_o,
  // system
  output reg         boot_area_select_o,
  output reg         cpu_stall_o,
  output reg         wdt_hold_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BUSY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  function hit;
    input [11:0] adr;
    input [7:0]  idx;
    begin
      hit = (adr[11:10] == 2'h0) && (adr[9:2] == idx);
    end
  endfunction

  // registers
  reg  [7:0] unlock_timeout_key;
  reg  [7:0] target_address_low;
  reg  [7:0] target_address_high;
  reg  [7:0] region_selector;
  reg  [7:0] program_data_byte;
  reg        sector_erase_request;
  reg        byte_write_request;
  reg  [1:0] command_code;
  reg        refused;
  reg        done_flag;
  reg  [2:0] state;

  reg  [2:0] next_state;
  reg  [7:0] next_rdata;
  reg        launch;
  reg        reject;
  reg  [1:0] area;
  reg        area_ok;

  wire       key_enabled;
  wire [7:0] key_remaining;
  wire       access;
  wire       wr_take;
  wire       lane0;
  wire [7:0] wbyte;
  wire       key_wr;
  wire       ctl_wr;
  wire       sta_wr;
  wire [15:0] target_address;

  assign access  = wb_cyc_i && wb_stb_i;
  // a write takes effect at the edge where the master sees ack
  assign wr_take = access && wb_we_i && wb_ack_o;
  assign lane0   = wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];
  assign key_wr  = wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_KEY);
  assign ctl_wr  = wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_CONTROL);
  assign sta_wr  = wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_STATUS);
  assign target_address = {target_address_high, target_address_low}; // [R3] [R4]

  fsp_key_timer u_key (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .key_wr_i    (key_wr),
    .key_val_i   (wbyte),
    .consume_i   (launch || reject),
    .enabled_o   (key_enabled),
    .remaining_o (key_remaining)
  );

  // selector decode for programming target
  always @* begin
    area    = `FSP_AREA_MAIN;
    area_ok = 1'b0;
    case (region_selector)
      `FSP_REG_MAIN: begin
        area    = `FSP_AREA_MAIN; // [R5]
        area_ok = 1'b1;
      end
      `FSP_REG_UID: begin
        area    = `FSP_AREA_UID; // [R6]
        area_ok = 1'b0;
      end
      `FSP_REG_EEPROM: begin
        area    = `FSP_AREA_EEPROM; // [R7]
        area_ok = 1'b1;
      end
      `FSP_REG_BOOT: begin
        area    = `FSP_AREA_BOOT; // [R8] [R16]
        area_ok = 1'b0;
      end
      default: begin
        area    = `FSP_AREA_MAIN;
        area_ok = 1'b0;
      end
    endcase
  end

  // trigger evaluation: operation bit must already be stored
  always @* begin
    launch = 1'b0;
    reject = 1'b0;
    if (ctl_wr && (state == ST_IDLE)) begin
      if (wbyte[`FSP_CTL_CMD_HI:`FSP_CTL_CMD_LO] == `FSP_CMD_LAUNCH) begin // [R12]
        if ((sector_erase_request ^ byte_write_request) // [R10] [R11] [R13] [R14]
            && key_enabled && area_ok) begin // [R18]
          launch = 1'b1;
        end else begin
          reject = 1'b1;
        end
      end
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (flash_done_i) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // read mux
  always @* begin
    next_rdata = 8'h00;
    case (wb_adr_i[9:2])
      `FSP_IDX_KEY:       next_rdata = unlock_timeout_key;
      `FSP_IDX_ADDR_LOW:  next_rdata = target_address_low;
      `FSP_IDX_ADDR_HIGH: next_rdata = target_address_high;
      `FSP_IDX_REGION:    next_rdata = region_selector;
      `FSP_IDX_DATA:      next_rdata = program_data_byte;
      `FSP_IDX_CONTROL: begin
        next_rdata = {boot_area_select_o, 1'b0, sector_erase_request,
                      byte_write_request, 2'b00, command_code};
      end
      `FSP_IDX_STATUS: begin
        next_rdata = {4'h0, done_flag, refused, cpu_stall_o, key_enabled};
      end
      default:            next_rdata = 8'h00;
    endcase
    if (wb_adr_i[11:10] != 2'h0) begin
      next_rdata = 8'h00;
    end
  end

  // bus answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access && !wb_ack_o;
      if (access && !wb_ack_o) begin
        wb_dat_o <= {24'h000000, next_rdata};
      end
    end
  end

  // software registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      unlock_timeout_key   <= `FSP_RST_BYTE;
      target_address_low   <= `FSP_RST_BYTE;
      target_address_high  <= `FSP_RST_BYTE;
      region_selector      <= `FSP_RST_BYTE;
      program_data_byte    <= `FSP_RST_BYTE;
      boot_area_select_o   <= 1'b0;
      sector_erase_request <= 1'b0;
      byte_write_request   <= 1'b0;
      command_code         <= `FSP_CMD_IDLE;
    end else begin
      if (key_wr) begin
        unlock_timeout_key <= wbyte;
      end
      if (wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_ADDR_LOW)) begin
        target_address_low <= wbyte; // [R3]
      end
      if (wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_ADDR_HIGH)) begin
        target_address_high <= wbyte; // [R4]
      end
      if (wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_REGION)) begin
        region_selector <= wbyte;
      end
      if (wr_take && lane0 && hit(wb_adr_i, `FSP_IDX_DATA)) begin
        program_data_byte <= wbyte;
      end
      if (ctl_wr) begin
        boot_area_select_o   <= wbyte[`FSP_CTL_BOOT_BIT]; // [R9]
        sector_erase_request <= wbyte[`FSP_CTL_ERASE_BIT];
        byte_write_request   <= wbyte[`FSP_CTL_WRITE_BIT];
        command_code         <= wbyte[`FSP_CTL_CMD_HI:`FSP_CTL_CMD_LO];
      end else if (state == ST_DONE) begin
        // finished command returns to idle code
        command_code <= `FSP_CMD_IDLE;
      end
    end
  end

  // sticky status, set wins over write-one clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      refused   <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      if (reject) begin
        refused <= 1'b1;
      end else if (sta_wr && wbyte[`FSP_STA_REFUSED]) begin
        refused <= 1'b0;
      end
      if (state == ST_DONE) begin
        done_flag <= 1'b1;
      end else if (sta_wr && wbyte[`FSP_STA_DONE]) begin
        done_flag <= 1'b0;
      end
    end
  end

  // flash operation sequencing
  always @(posedge clk_i) begin
    if (rst_i) begin
      state         <= ST_IDLE;
      flash_write_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_addr_o  <= 16'h0000;
      flash_area_o  <= `FSP_AREA_MAIN;
      flash_data_o  <= 8'h00;
      cpu_stall_o   <= 1'b0;
      wdt_hold_o    <= 1'b0;
    end else begin
      state <= next_state;
      if (launch) begin
        flash_erase_o <= sector_erase_request; // [R10]
        flash_write_o <= byte_write_request; // [R11]
        flash_addr_o  <= target_address;
        flash_area_o  <= area;
        flash_data_o  <= program_data_byte;
        cpu_stall_o   <= 1'b1; // [R19]
        wdt_hold_o    <= 1'b1; // [R17]
      end else if ((state == ST_BUSY) && flash_done_i) begin
        flash_erase_o <= 1'b0;
        flash_write_o <= 1'b0;
        cpu_stall_o   <= 1'b0; // [R19]
        wdt_hold_o    <= 1'b0; // [R17]
      end
    end
  end

  // table read target
  always @(posedge clk_i) begin
    if (rst_i) begin
      read_area_o  <= `FSP_AREA_MAIN;
      read_allow_o <= 1'b1;
    end else begin
      case (region_selector)
        `FSP_REG_MAIN: begin
          read_area_o  <= `FSP_AREA_MAIN; // [R5]
          read_allow_o <= 1'b1;
        end
        `FSP_REG_UID: begin
          read_area_o  <= `FSP_AREA_UID; // [R6]
          read_allow_o <= 1'b1;
        end
        `FSP_REG_EEPROM: begin
          read_area_o  <= `FSP_AREA_EEPROM; // [R7]
          read_allow_o <= 1'b1;
        end
        `FSP_REG_BOOT: begin
          read_area_o  <= `FSP_AREA_BOOT;
          read_allow_o <= exec_in_boot_i; // [R8]
        end
        default: begin
          read_area_o  <= `FSP_AREA_MAIN;
          read_allow_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* test/fsp_ctrl_monitor.sv */
// assertion checker for the flash program controller
`include "fsp_regs.vh"
module fsp_ctrl_monitor (
  // clock and reset
  input logic        clk_i,
  input logic        rst_i,
  // wishbone
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [11:0] wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  // flash and system
  input logic        flash_write_o,
  input logic        flash_erase_o,
  input logic [15:0] flash_addr_o,
  input logic [1:0]  flash_area_o,
  input logic        flash_done_i,
  input logic        cpu_stall_o,
  input logic        wdt_hold_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire busy = flash_write_o || flash_erase_o;
  wire trig = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
              && wb_adr_i[9:2] == `FSP_IDX_CONTROL && wb_dat_i[1:0] == `FSP_CMD_LAUNCH;
  sequence s_busy;
    busy && !flash_done_i;
  endsequence
  sequence s_finish;
    busy && flash_done_i;
  endsequence
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not in next cycle");
  property p_one_op;
    !(flash_write_o && flash_erase_o);
  endproperty
  a_one_op: assert property (p_one_op) else $error("write and erase together");
  property p_stall;
    cpu_stall_o == busy;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not matching operation");
  property p_wdt;
    wdt_hold_o == busy;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog hold not matching");
  property p_area;
    busy |-> flash_area_o == `FSP_AREA_MAIN || flash_area_o == `FSP_AREA_EEPROM;
  endproperty
  a_area: assert property (p_area) else $error("operation on refused area");
  property p_launch;
    $rose(busy) |-> $past(trig);
  endproperty
  a_launch: assert property (p_launch) else $error("launch without trigger");
  property p_end;
    s_finish |=> !busy;
  endproperty
  a_end: assert property (p_end) else $error("operation not ended by done");
  property p_hold;
    s_busy |=> busy && $stable(flash_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved during operation");
endmodule
bind fsp_ctrl fsp_ctrl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .flash_write_o(flash_write_o),
  .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o), .flash_area_o(flash_area_o),
  .flash_done_i(flash_done_i), .cpu_stall_o(cpu_stall_o), .wdt_hold_o(wdt_hold_o));

/* test/tb_top.sv */
// self-checking bench for the flash program controller
`include "fsp_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        flash_done_i = 1'b0;
  logic        exec_in_boot_i = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic [15:0] flash_addr_o;
  logic [7:0]  flash_data_o;
  logic [1:0]  flash_area_o, read_area_o;
  logic        wb_ack_o, flash_write_o, flash_erase_o, read_allow_o;
  logic        boot_area_select_o, cpu_stall_o, wdt_hold_o;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  fsp_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_write_o(flash_write_o),
    .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o), .flash_area_o(flash_area_o),
    .flash_data_o(flash_data_o), .flash_done_i(flash_done_i), .exec_in_boot_i(exec_in_boot_i),
    .read_area_o(read_area_o), .read_allow_o(read_allow_o),
    .boot_area_select_o(boot_area_select_o), .cpu_stall_o(cpu_stall_o),
    .wdt_hold_o(wdt_hold_o));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; ack and read data taken at the rising edge, released there
  task automatic wb(logic we, logic [7:0] idx, logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic t_reset();
    for (int i = 8'hF1; i <= 8'hF7; i++) begin
      wb(1'b0, i[7:0], 8'h00);
      chk("reset value", 32'h0, rd);
    end
    wb(1'b0, 8'h10, 8'h00);
    chk("unmapped read", 32'h0, rd);
    chk("read allow", 32'h1, read_allow_o);
    $display("done reset");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `FSP_IDX_ADDR_LOW + i[7:0], 8'hA1 + i[7:0]);
      wb(1'b0, `FSP_IDX_ADDR_LOW + i[7:0], 8'h00);
      chk("register", 32'hA1 + i, rd);
    end
    wb(1'b1, `FSP_IDX_KEY, 8'h3F);
    wb(1'b0, `FSP_IDX_STATUS, 8'h00);
    chk("small key", 32'h0, rd[0]);
    wb(1'b1, `FSP_IDX_KEY, 8'h40);
    wb(1'b0, `FSP_IDX_STATUS, 8'h00);
    chk("key enabled", 32'h1, rd[0]);
    wb(1'b1, `FSP_IDX_KEY, 8'h00);
    wb(1'b1, `FSP_IDX_CONTROL, 8'h80);
    wb(1'b0, `FSP_IDX_CONTROL, 8'h00);
    chk("control", 32'h80, rd);
    chk("boot select", 32'h1, boot_area_select_o);
    wb(1'b1, `FSP_IDX_CONTROL, 8'h4C);
    wb(1'b0, `FSP_IDX_CONTROL, 8'h00);
    chk("control reserved", 32'h0, rd);
    chk("boot select", 32'h0, boot_area_select_o);
    $display("done registers");
  endtask
  task automatic t_op(logic [7:0] op, logic [7:0] sel, logic [7:0] key, int dly,
                      logic [1:0] cmd, logic exp);
    wb(1'b1, `FSP_IDX_ADDR_LOW, 8'h34);
    wb(1'b1, `FSP_IDX_ADDR_HIGH, 8'h12);
    wb(1'b1, `FSP_IDX_DATA, 8'hA5);
    wb(1'b1, `FSP_IDX_REGION, sel);
    wb(1'b1, `FSP_IDX_CONTROL, op);
    wb(1'b1, `FSP_IDX_KEY, key);
    repeat (dly) @(posedge clk_i);
    wb(1'b1, `FSP_IDX_CONTROL, op | {6'h00, cmd});
    @(negedge clk_i);
    chk("launch", exp, flash_write_o | flash_erase_o);
    if (exp) begin
      chk("write", op[4], flash_write_o);
      chk("erase", op[5], flash_erase_o);
      chk("address", 32'h1234, flash_addr_o);
      chk("data", 32'hA5, flash_data_o);
      chk("area", sel[1:0], flash_area_o);
      chk("stall", 32'h1, cpu_stall_o);
      chk("wdt hold", 32'h1, wdt_hold_o);
      repeat (12) @(posedge clk_i);
      flash_done_i <= 1'b1;
      @(posedge clk_i);
      flash_done_i <= 1'b0;
      @(negedge clk_i);
      chk("end", 32'h0, flash_write_o | flash_erase_o | cpu_stall_o);
      wb(1'b0, `FSP_IDX_STATUS, 8'h00);
      chk("done flag", 32'h1, rd[3]);
    end else begin
      wb(1'b0, `FSP_IDX_STATUS, 8'h00);
      chk("refused", cmd == 2'h2, rd[2]);
    end
    wb(1'b1, `FSP_IDX_STATUS, 8'h0C);
    wb(1'b1, `FSP_IDX_CONTROL, 8'h00);
    $display("done operation %h %h", op, sel);
  endtask
  task automatic t_read();
    logic [7:0] s [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, `FSP_IDX_REGION, s[i]);
      repeat (2) @(negedge clk_i);
      if (i < 4) chk("read area", s[i][1:0], read_area_o);
      chk("read allow", i < 3, read_allow_o);
    end
    @(posedge clk_i);
    exec_in_boot_i <= 1'b1;
    wb(1'b1, `FSP_IDX_REGION, 8'h03);
    repeat (2) @(negedge clk_i);
    chk("boot read", 32'h1, read_allow_o);
    $display("done table read");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_op(8'h10, 8'h00, 8'h40, 0, 2'h2, 1'b1);
    t_op(8'h20, 8'h02, 8'hFF, 0, 2'h2, 1'b1);
    t_op(8'h10, 8'h00, 8'h40, 50, 2'h2, 1'b1);
    t_op(8'h10, 8'h00, 8'h40, 70, 2'h2, 1'b0);
    t_op(8'h10, 8'h00, 8'h3F, 0, 2'h2, 1'b0);
    t_op(8'h10, 8'h00, 8'h00, 0, 2'h2, 1'b0);
    t_op(8'h10, 8'h01, 8'h40, 0, 2'h2, 1'b0);
    t_op(8'h10, 8'h03, 8'h40, 0, 2'h2, 1'b0);
    for (int c = 0; c < 4; c += 1 + (c == 1)) t_op(8'h20, 8'h00, 8'h40, 0, c[1:0], 1'b0);
    t_op(8'h30, 8'h00, 8'h40, 0, 2'h2, 1'b0);
    t_op(8'h00, 8'h00, 8'h40, 0, 2'h2, 1'b0);
    t_read();
    t_op(8'h10, 8'h03, 8'h40, 0, 2'h2, 1'b0);
    wrap_up();
  end
endmodule
